// ==== rtl/bcg_cfg.svh ====
// Purpose: Constants for the back-channel GPIO and frame pulse block
// Assumes: 200 MHz reference clock, byte-wide register port
// Notes:   Behaviour list follows
// Behaviour
// - Four general pins, each with its own function control.
// - Each pin can be an input whose level goes onto the back channel.
// - Every slot of every receive port can carry any of the four pins.
// - One pin may feed many slots on both ports at once.
// - Any slot may carry the frame pulse instead of a pin.
// - Slot sources live per port in registers 0x6E and 0x6F.
// - Register 0x0E reads each pin level, input or output alike.
// - Input enable 0x0F and pulldown 0xBE, both enabled after reset.
// - Source 0x8 to 0xB with generator off selects external pin pulse.
// - Generator enable bit set to 1 turns on internal generation.
// - Generator repeats high and low phases until disabled.
// - One tick is one back-channel frame, 12 us at 2.5 Mbps.
// - Source field 0x18[7:4] picks tick source; 0x0 is port 0.
// - Bit 0x18[1] low: separate high/low counts; high: 50/50 duty.
// - Bit 0x18[2] sets starting level when generation begins.
// - High count is 16 bits: upper byte 0x19, lower byte 0x1A.
// - Low count is 16 bits: upper byte 0x1B, lower byte 0x1C.
// - Field 0x58[2:0] picks back-channel rate; 0x0 is 2.5 Mbps.
`ifndef BCG_CFG_SVH
`define BCG_CFG_SVH
`define BCG_ADDR_PIN_STS   8'h0E
`define BCG_ADDR_PIN_IE    8'h0F
`define BCG_ADDR_GEN_CTL   8'h18
`define BCG_ADDR_HIGH_U    8'h19
`define BCG_ADDR_HIGH_L    8'h1A
`define BCG_ADDR_LOW_U     8'h1B
`define BCG_ADDR_LOW_L     8'h1C
`define BCG_ADDR_PORT_SEL  8'h4C
`define BCG_ADDR_RATE      8'h58
`define BCG_ADDR_SLOT_A    8'h6E
`define BCG_ADDR_SLOT_B    8'h6F
`define BCG_ADDR_PULLDOWN  8'hBE
`define BCG_RST_PIN_IE     4'hF
`define BCG_RST_PULLDOWN   4'hF
`define BCG_RST_PORT_SEL   8'h01
`define BCG_BIT_GEN_ON     0
`define BCG_BIT_DUTY       1
`define BCG_BIT_START_LVL  2
`define BCG_BIT_RD_PORT    4
`define BCG_BIT_TICK_PORT  0
`define BCG_FLD_SRC        7:4
`define BCG_FLD_EXT_PIN    1:0
`define BCG_FLD_RATE       2:0
`define BCG_FLD_SLOT_LO    3:0
`define BCG_FLD_SLOT_HI    7:4
`define BCG_SEL_PIN_END    4'h4
`define BCG_SRC_EXT_MIN    4'h8
`define BCG_SRC_EXT_MAX    4'hB
`define BCG_SEL_FRAME      4'hA
`define BCG_RATE_2P5       3'h0
`define BCG_CLK_PERIOD_NS  5
`define BCG_TICK_BITS      30
`define BCG_BIT_NS         400
`define BCG_TICK_NS        (`BCG_TICK_BITS * `BCG_BIT_NS)
`define BCG_TICK_CYC       (`BCG_TICK_NS / `BCG_CLK_PERIOD_NS)
`endif

// ==== rtl/bcg_pkg.sv ====
// Purpose: Shared types for the back-channel GPIO block
// Assumes: Nothing beyond the config header
// Notes:   Types only
package bcg_pkg;
  typedef logic [3:0]  bcg_sel_t;
  typedef logic [15:0] bcg_count_t;
  typedef logic [11:0] bcg_tick_t;
endpackage

// ==== rtl/bcg_top.sv ====
// Purpose: Pin to back-channel slot routing and frame pulse generator
// Assumes: Pads settle outside this clock; other logic drives pin outputs
// Notes:   Register reads answer one cycle after the read strobe
`include "bcg_cfg.svh"
module bcg_top #(
  parameter int PINS         = 4,
  parameter int PORTS        = 2,
  parameter int SLOTS        = 4,
  parameter int ALT_TICK_CYC = 1200
) (
  input  wire logic               ref_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic [PINS-1:0]    pin_pad_in,
  input  wire logic [PINS-1:0]    pin_out_en_in,
  input  wire logic [PINS-1:0]    pin_out_val_in,
  output logic      [PINS-1:0]    pin_oe_out,
  output logic      [PINS-1:0]    pin_drv_out,
  output logic      [PINS-1:0]    pin_input_en_out,
  output logic      [PINS-1:0]    pin_pulldown_en_out,
  input  wire logic [7:0]         reg_addr_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  input  wire logic [7:0]         reg_wdata_in,
  output logic      [7:0]         reg_rdata_out,
  output logic [PORTS*SLOTS-1:0]  slot_out,
  output logic                    frame_pulse_out
);
  localparam int TICK_CYC = `BCG_TICK_CYC;

  logic [PINS-1:0]  pad_meta;
  logic [PINS-1:0]  pad_sync;
  logic [PINS-1:0]  pin_ie;
  logic [PINS-1:0]  pin_pd;
  logic [7:0]       gen_ctl;
  logic [7:0]       high_u;
  logic [7:0]       high_l;
  logic [7:0]       low_u;
  logic [7:0]       low_l;
  logic [7:0]       port_sel;
  bcg_pkg::bcg_sel_t slot_sel [PORTS][SLOTS];
  logic [2:0]       rate [PORTS];
  bcg_pkg::bcg_tick_t tick_cnt;
  bcg_pkg::bcg_count_t gen_cnt;
  logic             gen_on_q;
  logic             gen_level;
  logic             frame_q;

  // Pads drive only when function logic asks
  assign pin_oe_out          = pin_out_en_in;
  assign pin_drv_out         = pin_out_val_in;
  assign pin_input_en_out    = pin_ie;
  assign pin_pulldown_en_out = pin_pd;

  // Pads are asynchronous to the clock
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_meta <= '0;
      pad_sync <= '0;
    end else begin
      pad_meta <= pin_pad_in;
      pad_sync <= pad_meta;
    end
  end

  // Disabled input path reads as low level toward the slots
  wire [PINS-1:0] pin_lvl = pad_sync & pin_ie;

  wire wr_ie    = reg_wr_in && (reg_addr_in == `BCG_ADDR_PIN_IE);
  wire wr_pd    = reg_wr_in && (reg_addr_in == `BCG_ADDR_PULLDOWN);
  wire wr_ctl   = reg_wr_in && (reg_addr_in == `BCG_ADDR_GEN_CTL);
  wire wr_hu    = reg_wr_in && (reg_addr_in == `BCG_ADDR_HIGH_U);
  wire wr_hl    = reg_wr_in && (reg_addr_in == `BCG_ADDR_HIGH_L);
  wire wr_lu    = reg_wr_in && (reg_addr_in == `BCG_ADDR_LOW_U);
  wire wr_ll    = reg_wr_in && (reg_addr_in == `BCG_ADDR_LOW_L);
  wire wr_psel  = reg_wr_in && (reg_addr_in == `BCG_ADDR_PORT_SEL);
  wire wr_rate  = reg_wr_in && (reg_addr_in == `BCG_ADDR_RATE);
  wire wr_sel_a = reg_wr_in && (reg_addr_in == `BCG_ADDR_SLOT_A);
  wire wr_sel_b = reg_wr_in && (reg_addr_in == `BCG_ADDR_SLOT_B);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_ie   <= `BCG_RST_PIN_IE;
      pin_pd   <= `BCG_RST_PULLDOWN;
      gen_ctl  <= 8'h00;
      high_u   <= 8'h00;
      high_l   <= 8'h00;
      low_u    <= 8'h00;
      low_l    <= 8'h00;
      port_sel <= `BCG_RST_PORT_SEL;
    end else begin
      if (wr_ie)   pin_ie   <= reg_wdata_in[PINS-1:0];
      if (wr_pd)   pin_pd   <= reg_wdata_in[PINS-1:0];
      if (wr_ctl)  gen_ctl  <= reg_wdata_in;
      if (wr_hu)   high_u   <= reg_wdata_in;
      if (wr_hl)   high_l   <= reg_wdata_in;
      if (wr_lu)   low_u    <= reg_wdata_in;
      if (wr_ll)   low_l    <= reg_wdata_in;
      if (wr_psel) port_sel <= reg_wdata_in;
    end
  end

  // Banked per-port registers; a write may hit both banks at once
  for (genvar p = 0; p < PORTS; p++) begin : g_bank
    wire bank_wr = port_sel[p];
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        rate[p] <= `BCG_RATE_2P5;
        for (int s = 0; s < SLOTS; s++) begin
          slot_sel[p][s] <= 4'h0;
        end
      end else begin
        if (wr_rate && bank_wr) begin
          rate[p] <= reg_wdata_in[`BCG_FLD_RATE];
        end
        if (wr_sel_a && bank_wr) begin
          slot_sel[p][0] <= reg_wdata_in[`BCG_FLD_SLOT_LO];
          slot_sel[p][1] <= reg_wdata_in[`BCG_FLD_SLOT_HI];
        end
        if (wr_sel_b && bank_wr) begin
          slot_sel[p][2] <= reg_wdata_in[`BCG_FLD_SLOT_LO];
          slot_sel[p][3] <= reg_wdata_in[`BCG_FLD_SLOT_HI];
        end
      end
    end
  end

  // Read bank chosen by one select bit
  wire rd_port = port_sel[`BCG_BIT_RD_PORT];
  wire [7:0] rd_sel_a = {slot_sel[rd_port][1], slot_sel[rd_port][0]};
  wire [7:0] rd_sel_b = {slot_sel[rd_port][3], slot_sel[rd_port][2]};
  wire [7:0] rd_mux =
    (reg_addr_in == `BCG_ADDR_PIN_STS)  ? {4'h0, pad_sync} :
    (reg_addr_in == `BCG_ADDR_PIN_IE)   ? {4'h0, pin_ie} :
    (reg_addr_in == `BCG_ADDR_PULLDOWN) ? {4'h0, pin_pd} :
    (reg_addr_in == `BCG_ADDR_GEN_CTL)  ? gen_ctl :
    (reg_addr_in == `BCG_ADDR_HIGH_U)   ? high_u :
    (reg_addr_in == `BCG_ADDR_HIGH_L)   ? high_l :
    (reg_addr_in == `BCG_ADDR_LOW_U)    ? low_u :
    (reg_addr_in == `BCG_ADDR_LOW_L)    ? low_l :
    (reg_addr_in == `BCG_ADDR_PORT_SEL) ? port_sel :
    (reg_addr_in == `BCG_ADDR_RATE)     ? {5'h00, rate[rd_port]} :
    (reg_addr_in == `BCG_ADDR_SLOT_A)   ? rd_sel_a :
    (reg_addr_in == `BCG_ADDR_SLOT_B)   ? rd_sel_b : 8'h00;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) reg_rdata_out <= 8'h00;
    else if (reg_rd_in) reg_rdata_out <= rd_mux;
  end

  // Tick source: frame period of the port named by the source field
  wire [3:0] src      = gen_ctl[`BCG_FLD_SRC];
  wire       tick_prt = src[`BCG_BIT_TICK_PORT];
  wire       gen_on   = gen_ctl[`BCG_BIT_GEN_ON];
  // Only the 2.5 Mbps period is known; others use a parameter
  wire bcg_pkg::bcg_tick_t tick_len = (rate[tick_prt] == `BCG_RATE_2P5) ?
    bcg_pkg::bcg_tick_t'(TICK_CYC) : bcg_pkg::bcg_tick_t'(ALT_TICK_CYC);
  wire tick = (tick_cnt >= tick_len - 12'h001);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) tick_cnt <= 12'h000;
    else if (tick) tick_cnt <= 12'h000;
    else tick_cnt <= tick_cnt + 12'h001;
  end

  // 50/50 uses the high count for both phases
  wire bcg_pkg::bcg_count_t high_cnt = {high_u, high_l};
  wire bcg_pkg::bcg_count_t low_cnt  = {low_u, low_l};
  wire duty_even = gen_ctl[`BCG_BIT_DUTY];
  wire bcg_pkg::bcg_count_t phase_len =
    (gen_level || duty_even) ? high_cnt : low_cnt;
  wire bcg_pkg::bcg_count_t cnt_inc = gen_cnt + 16'h0001;
  wire gen_start = gen_on && !gen_on_q;
  wire phase_end = tick && (cnt_inc >= phase_len);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gen_on_q  <= 1'b0;
      gen_level <= 1'b0;
      gen_cnt   <= 16'h0000;
    end else begin
      gen_on_q <= gen_on;
      if (!gen_on) begin
        gen_level <= 1'b0;
        gen_cnt   <= 16'h0000;
      end else if (gen_start) begin
        gen_level <= gen_ctl[`BCG_BIT_START_LVL];
        gen_cnt   <= 16'h0000;
      end else if (phase_end) begin
        gen_level <= !gen_level;
        gen_cnt   <= 16'h0000;
      end else if (tick) begin
        gen_cnt <= cnt_inc;
      end
    end
  end

  wire ext_mode = !gen_on && (src >= `BCG_SRC_EXT_MIN) &&
                  (src <= `BCG_SRC_EXT_MAX);
  wire next_frame = gen_on ? gen_level :
                    ext_mode ? pin_lvl[src[`BCG_FLD_EXT_PIN]] : 1'b0;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) frame_q <= 1'b0;
    else frame_q <= next_frame;
  end
  assign frame_pulse_out = frame_q;

  // Each slot is an independent mux, so one pin can fan out freely
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      wire bcg_pkg::bcg_sel_t sel = slot_sel[p][s];
      wire next_slot = (sel < `BCG_SEL_PIN_END) ?
                       pin_lvl[sel[1:0]] :
                       (sel == `BCG_SEL_FRAME) ? next_frame : 1'b0;
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) slot_out[p*SLOTS+s] <= 1'b0;
        else slot_out[p*SLOTS+s] <= next_slot;
      end
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_status_read;
    reg_rd_in && reg_addr_in == `BCG_ADDR_PIN_STS
      |=> reg_rdata_out == {4'h0, $past(pad_sync)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("pin status read mismatch");

  property p_slot_pin;
    slot_sel[1][0] < 4'h4 |=> slot_out[SLOTS] ==
      $past(pin_lvl[slot_sel[1][0][1:0]]);
  endproperty
  a_slot_pin: assert property (p_slot_pin)
    else $error("slot does not follow selected pin");

  property p_fanout;
    slot_sel[0][3] < `BCG_SEL_PIN_END && slot_sel[1][2] == slot_sel[0][3]
      |=> slot_out[3] == slot_out[SLOTS+2] &&
          slot_out[3] == $past(pin_lvl[slot_sel[0][3][1:0]]);
  endproperty
  a_fanout: assert property (p_fanout)
    else $error("shared pin gives different slot levels");

  property p_slot_frame;
    slot_sel[0][2] == `BCG_SEL_FRAME |=> slot_out[2] == frame_q;
  endproperty
  a_slot_frame: assert property (p_slot_frame)
    else $error("slot does not carry frame pulse");

  property p_ie_gate;
    !pin_ie[1] && slot_sel[0][0] == 4'h1 |=> !slot_out[0];
  endproperty
  a_ie_gate: assert property (p_ie_gate)
    else $error("disabled input reached a slot");

  property p_ext;
    ext_mode |=> frame_q == $past(pin_lvl[src[1:0]]);
  endproperty
  a_ext: assert property (p_ext)
    else $error("external pulse not forwarded");

  property p_off;
    !gen_on |=> !gen_level;
  endproperty
  a_off: assert property (p_off)
    else $error("generator output while disabled");

  property p_start;
    gen_start |=> gen_level == $past(gen_ctl[`BCG_BIT_START_LVL]);
  endproperty
  a_start: assert property (p_start)
    else $error("wrong start level");

  property p_hold;
    gen_on && gen_on_q && !tick |=> $stable(gen_level);
  endproperty
  a_hold: assert property (p_hold)
    else $error("generator toggled between ticks");

  property p_tick_gap;
    tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("ticks too close together");

  property p_bank;
    wr_sel_a && port_sel[1:0] == 2'b10 |=> $stable(slot_sel[0][0]);
  endproperty
  a_bank: assert property (p_bank)
    else $error("unselected bank was written");

  property p_high_pair;
    wr_hu |=> high_cnt == {$past(reg_wdata_in), $past(high_l)};
  endproperty
  a_high_pair: assert property (p_high_pair)
    else $error("high count upper byte not paired");

  property p_low_pair;
    wr_ll |=> low_cnt == {$past(low_u), $past(reg_wdata_in)};
  endproperty
  a_low_pair: assert property (p_low_pair)
    else $error("low count lower byte not paired");

  c_gen_toggle: cover property (gen_on && gen_on_q && phase_end);
  c_ext_frame:  cover property (ext_mode && $rose(frame_q));
  c_slot_frame: cover property (slot_sel[0][2] == `BCG_SEL_FRAME
                                && $rose(slot_out[2]));
  c_duty_even:  cover property (gen_on && duty_even && phase_end);
  c_start_high: cover property (gen_start && gen_ctl[`BCG_BIT_START_LVL]);
endmodule

// ==== tb/bcg_slot_rx_model.sv ====
// Purpose: Remote serializer end receiving back-channel slots
// Assumes: Slot levels are sampled on the block clock
// Notes:   Counts rising edges seen on one watched slot
module bcg_slot_rx_model #(
  parameter int IDX = 2
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  slot_in,
  output logic      [15:0] rise_out
);
  logic last;
  // Listen only; nothing is sent back to the block
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last     <= 1'b0;
      rise_out <= 16'h0000;
    end else begin
      last <= slot_in[IDX];
      if (slot_in[IDX] && !last) begin
        rise_out <= rise_out + 16'h0001;
      end
    end
  end
endmodule

// ==== tb/backchannel_gpio_frame_pulse_bench.sv ====
// Purpose: Register-driven checks of slot routing and frame pulse
// Assumes: Inputs change on the falling edge
// Notes:   Short alternate tick keeps generator phases brief
module backchannel_gpio_frame_pulse_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 30 * 400 / 5;
  logic        clk;
  logic        rst_n;
  logic [3:0]  pad;
  logic [3:0]  oen;
  logic [3:0]  oval;
  logic [3:0]  oe;
  logic [3:0]  drv;
  logic [3:0]  ie;
  logic [3:0]  pd;
  logic [7:0]  addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  slots;
  logic        frame;
  logic [15:0] rises;
  logic [15:0] base;
  int          n_fail;
  int          checked;

  bcg_top #(.ALT_TICK_CYC(10)) dut_u (
    .ref_clk_in(clk), .rst_n_in(rst_n), .pin_pad_in(pad),
    .pin_out_en_in(oen), .pin_out_val_in(oval), .pin_oe_out(oe),
    .pin_drv_out(drv), .pin_input_en_out(ie), .pin_pulldown_en_out(pd),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .slot_out(slots),
    .frame_pulse_out(frame)
  );
  bcg_slot_rx_model #(.IDX(2)) rx_u (
    .clk_in(clk), .rst_n_in(rst_n), .slot_in(slots), .rise_out(rises)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  // Counts one level run up to the next edge of the pulse
  task automatic phase(output logic lvl, output int n);
    lvl = frame;
    n = 0;
    while (frame === lvl && n < 20000) begin
      @(negedge clk);
      n++;
    end
  endtask

  // First run is partial since the tick counter runs free
  task automatic gen_chk(input int hi, input int lo);
    logic l;
    int   n;
    phase(l, n);
    repeat (2) begin
      phase(l, n);
      chk(16'(n), l ? 16'(hi) : 16'(lo));
    end
  endtask

  initial begin
    #300us;
    n_fail++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    pad = 4'h0;
    oen = 4'h5;
    oval = 4'h3;
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    repeat (4) @(negedge clk);
    chk({8'h00, ie, pd}, 16'h00FF);
    rst_n = 1'b1;
    chk({8'h00, oe, drv}, 16'h0053);
    oen = 4'hA;
    oval = 4'hC;
    @(negedge clk);
    chk({8'h00, oe, drv}, 16'h00AC);
    rd_chk(8'h0F, 8'h0F);
    rd_chk(8'hBE, 8'h0F);
    rd_chk(8'h4C, 8'h01);
    rd_chk(8'h00, 8'h00);
    wr_reg(8'hBE, 8'h06);
    chk({12'h000, pd}, 16'h0006);
    pad = 4'hA;
    repeat (4) @(negedge clk);
    wr_reg(8'h0E, 8'hFF);
    rd_chk(8'h0E, 8'h0A);
    wr_reg(8'h4C, 8'h03);
    wr_reg(8'h6E, 8'h21);
    wr_reg(8'h6F, 8'h33);
    repeat (2) @(negedge clk);
    chk({8'h00, slots}, 16'h00DD);
    wr_reg(8'h4C, 8'h02);
    wr_reg(8'h6E, 8'h00);
    repeat (2) @(negedge clk);
    chk({8'h00, slots}, 16'h00CD);
    wr_reg(8'h4C, 8'h10);
    rd_chk(8'h6E, 8'h00);
    wr_reg(8'h4C, 8'h00);
    rd_chk(8'h6E, 8'h21);
    rd_chk(8'h6F, 8'h33);
    wr_reg(8'h0F, 8'h0D);
    repeat (2) @(negedge clk);
    chk({4'h0, ie, slots}, 16'h0DCC);
    wr_reg(8'h0F, 8'h0F);
    wr_reg(8'h4C, 8'h01);
    wr_reg(8'h6F, 8'hAA);
    repeat (2) @(negedge clk);
    base = rises;
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h18, {4'(8 + i), 4'h0});
      pad = 4'h1 << i;
      repeat (6) @(negedge clk);
      chk({13'h0, frame, slots[3:2]}, 16'h0007);
      pad = ~(4'h1 << i);
      repeat (6) @(negedge clk);
      chk({13'h0, frame, slots[3:2]}, 16'h0000);
    end
    chk(rises - base, 16'h0004);
    wr_reg(8'h18, 8'h70);
    pad = 4'hF;
    repeat (6) @(negedge clk);
    chk({15'h0, frame}, 16'h0000);
    wr_reg(8'h4C, 8'h02);
    wr_reg(8'h58, 8'h01);
    wr_reg(8'h4C, 8'h11);
    rd_chk(8'h58, 8'h01);
    wr_reg(8'h4C, 8'h01);
    rd_chk(8'h58, 8'h00);
    wr_reg(8'h19, 8'h01);
    wr_reg(8'h1A, 8'h00);
    wr_reg(8'h1B, 8'h01);
    wr_reg(8'h1C, 8'h03);
    rd_chk(8'h1C, 8'h03);
    wr_reg(8'h18, 8'h11);
    gen_chk(2560, 2590);
    wr_reg(8'h18, 8'h13);
    gen_chk(2560, 2560);
    wr_reg(8'h18, 8'h10);
    repeat (4) @(negedge clk);
    chk({15'h0, frame}, 16'h0000);
    wr_reg(8'h18, 8'h15);
    repeat (4) @(negedge clk);
    chk({15'h0, frame}, 16'h0001);
    wr_reg(8'h19, 8'h00);
    wr_reg(8'h1A, 8'h01);
    wr_reg(8'h18, 8'h03);
    gen_chk(TICK, TICK);
    final_report();
  end
endmodule
